// ==== logic/ara_defs.svh ====
// Constants for the conversion request arbiter
`ifndef ARA_DEFS_SVH
`define ARA_DEFS_SVH
`define ARA_NUM_CHAN 19
`define ARA_CHAN_W 5
`define ARA_RES_W 12
`define ARA_CHG_CHAN 5'h11
`define ARA_BUSREG_CHAN 5'h0b
`define ARA_CODE_MAX 12'hfff
`define ARA_CODE_MIN 12'h000
`define ARA_CONV_NS 1000
`define ARA_CLK_NS 5
`define ARA_CONV_CYC ((`ARA_CONV_NS + `ARA_CLK_NS - 1) / `ARA_CLK_NS)
`endif

// ==== logic/ara_pkg.sv ====
// Types for the conversion request arbiter
package ara_pkg;
    typedef enum logic [4:0] {
        ARA_IDLE = 5'b00001,
        ARA_RT0 = 5'b00010,
        ARA_RT1 = 5'b00100,
        ARA_SOFT = 5'b01000,
        ARA_CHG = 5'b10000
    } ara_state_t;
    typedef enum logic [1:0] {
        ARA_SRC_NONE = 2'h0,
        ARA_SRC_RT = 2'h1,
        ARA_SRC_SOFT = 2'h2,
        ARA_SRC_CHG = 2'h3
    } ara_src_t;
endpackage : ara_pkg

// ==== logic/ara_lowest_two.sv ====
// Picks the two lowest-numbered selected channels
`timescale 1ns/1ps
`include "ara_defs.svh"
module ara_lowest_two #(
    parameter int NCH = `ARA_NUM_CHAN
) (
    // Channel selection
    input wire logic [NCH-1:0] sel,
    // Picks
    output logic [`ARA_CHAN_W-1:0] first,
    output logic [`ARA_CHAN_W-1:0] second,
    output logic count_one,
    output logic count_two
);
    logic [NCH-1:0] rest;
    function automatic logic [`ARA_CHAN_W:0] lowest(input logic [NCH-1:0] v);
        logic [`ARA_CHAN_W:0] r;
        r = '0;
        for (int i = NCH - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = {1'b1, i[`ARA_CHAN_W-1:0]};
            end
        end
        return r;
    endfunction : lowest
    always_comb begin
        logic [`ARA_CHAN_W:0] a;
        logic [`ARA_CHAN_W:0] b;
        b = '0;
        a = lowest(sel);
        rest = sel;
        rest[a[`ARA_CHAN_W-1:0]] = 1'b0;
        b = lowest(rest);
        first = a[`ARA_CHAN_W-1:0];
        second = b[`ARA_CHAN_W-1:0];
        count_one = a[`ARA_CHAN_W];
        count_two = a[`ARA_CHAN_W] & b[`ARA_CHAN_W];
    end
endmodule : ara_lowest_two

// ==== logic/ara_conv_timer.sv ====
// Conversion time counter for one converter slot
`timescale 1ns/1ps
`include "ara_defs.svh"
module ara_conv_timer #(
    parameter int CYC = `ARA_CONV_CYC
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // Control
    input wire logic start,
    input wire logic abort,
    // Status
    output logic done
);
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic run_q;
    logic run_d;
    initial begin
        if (CYC < 1 || CYC > 65535) begin
            $error("conversion cycle count out of range");
        end
    end
    always_comb begin
        cnt_d = cnt_q;
        run_d = run_q;
        if (abort) begin
            run_d = 1'b0;
        end else if (start) begin
            run_d = 1'b1;
            cnt_d = 16'(CYC - 1);
        end else if (run_q) begin
            if (cnt_q == 16'h0000) begin
                run_d = 1'b0;
            end else begin
                cnt_d = cnt_q - 16'h0001;
            end
        end
    end
    assign done = run_q & (cnt_q == 16'h0000) & ~abort;
    always_ff @(posedge core_clk) begin
        if (srst) begin
            cnt_q <= 16'h0000;
            run_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            run_q <= run_d;
        end
    end
endmodule : ara_conv_timer

// ==== logic/ara_arbiter.sv ====
// Conversion request arbiter for the general-purpose converter
// Overview of operation
// - Soft request bit launches asynchronous conversion
// - Soft result stored; irq only when unmasked
// - Realtime and charger outrank soft requests
// - Soft request waits; running conversion completes
// - Realtime irq raised after blocking sequence
// - Pending soft runs afterwards, then soft irq
// - Charger request self-enables converter
// - Charger conversion forces channel seventeen
// - Charger result internal, no interrupt
// - Realtime outranks charger monitor
// - Results are unsigned twelve-bit codes
// - Channel eleven only without power path
// - Channel seventeen only with power path
// - Realtime aborts others, which reschedule
// - Realtime converts two lowest selected channels
// - Realtime stores both results, raises irq
`timescale 1ns/1ps
`include "ara_defs.svh"
module ara_arbiter
    import ara_pkg::*;
#(
    parameter int NCH = `ARA_NUM_CHAN,
    parameter int CONV_CYC = `ARA_CONV_CYC
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // Host control
    input wire logic adc_enable_toggle,
    input wire logic [`ARA_CHAN_W-1:0] soft_channel_select,
    input wire logic soft_conv_request_bit,
    input wire logic [NCH-1:0] realtime_chan_sel,
    input wire logic soft_irq_mask,
    input wire logic realtime_irq_mask,
    input wire logic power_path_fuse,
    // Request sources
    input wire logic hw_trigger_pin,
    input wire logic charger_monitor,
    // Converter datapath
    input wire logic [`ARA_RES_W-1:0] conv_code,
    output logic [`ARA_CHAN_W-1:0] mux_chan,
    output logic conv_active,
    // Results
    output logic [7:0] soft_result_low,
    output logic [7:0] soft_result_high,
    output logic [`ARA_RES_W-1:0] realtime_result0,
    output logic [`ARA_RES_W-1:0] realtime_result1,
    output logic [`ARA_RES_W-1:0] charger_result,
    output logic charger_result_valid,
    // Events
    output logic soft_conv_done_irq,
    output logic realtime_conv_done_irq,
    output logic soft_pending
);
    initial begin
        if (NCH != `ARA_NUM_CHAN) begin
            $error("channel count must match the multiplexer");
        end
    end

    ara_state_t st_q, st_d;
    logic rt_pend_q, rt_pend_d;
    logic sw_pend_q, sw_pend_d;
    logic chg_pend_q, chg_pend_d;
    logic trig_q;
    logic start, abort, done;
    logic [`ARA_CHAN_W-1:0] mux_d;
    logic [`ARA_CHAN_W-1:0] rt_first, rt_second;
    logic rt_one, rt_two;
    logic [7:0] swl_d, swh_d;
    logic [`ARA_RES_W-1:0] rt0_d, rt1_d, chg_d;
    logic chg_v_d, sw_irq_d, rt_irq_d, act_d;
    logic [NCH-1:0] rt_sel_ok;

    // Fuse-gated channels are dropped from any selection
    function automatic logic chan_ok(input logic [`ARA_CHAN_W-1:0] c,
                                     input logic fuse);
        chan_ok = !((c == `ARA_BUSREG_CHAN) && fuse) &&
                  !((c == `ARA_CHG_CHAN) && !fuse) &&
                  (c < 5'(`ARA_NUM_CHAN));
    endfunction : chan_ok

    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            rt_sel_ok[i] = realtime_chan_sel[i] &
                           chan_ok(i[`ARA_CHAN_W-1:0], power_path_fuse);
        end
    end

    ara_lowest_two #(.NCH(NCH)) u_pick (
        .sel(rt_sel_ok),
        .first(rt_first),
        .second(rt_second),
        .count_one(rt_one),
        .count_two(rt_two)
    );

    ara_conv_timer #(.CYC(CONV_CYC)) u_timer (
        .core_clk(core_clk),
        .srst(srst),
        .start(start),
        .abort(abort),
        .done(done)
    );

    logic rt_edge;
    assign rt_edge = hw_trigger_pin & ~trig_q;

    always_comb begin
        st_d = st_q;
        start = 1'b0;
        abort = 1'b0;
        mux_d = mux_chan;
        act_d = conv_active;
        rt_pend_d = rt_pend_q | (rt_edge & adc_enable_toggle & rt_one);
        // Merge: a repeat while pending is a no-op
        sw_pend_d = sw_pend_q | (soft_conv_request_bit & adc_enable_toggle &
                    chan_ok(soft_channel_select, power_path_fuse));
        chg_pend_d = chg_pend_q | charger_monitor;
        swl_d = soft_result_low;
        swh_d = soft_result_high;
        rt0_d = realtime_result0;
        rt1_d = realtime_result1;
        chg_d = charger_result;
        chg_v_d = 1'b0;
        sw_irq_d = 1'b0;
        rt_irq_d = 1'b0;
        unique case (st_q)
            ARA_IDLE: begin
                // Fixed priority, realtime first
                if (rt_pend_d) begin
                    st_d = ARA_RT0;
                    rt_pend_d = 1'b0;
                    mux_d = rt_first;
                    start = 1'b1;
                    act_d = 1'b1;
                end else if (chg_pend_d && power_path_fuse) begin
                    st_d = ARA_CHG;
                    chg_pend_d = 1'b0;
                    mux_d = `ARA_CHG_CHAN;
                    start = 1'b1;
                    act_d = 1'b1;
                end else if (sw_pend_d) begin
                    st_d = ARA_SOFT;
                    mux_d = soft_channel_select;
                    start = 1'b1;
                    act_d = 1'b1;
                end else begin
                    // Charger request without a fitted path is dropped
                    chg_pend_d = 1'b0;
                    act_d = 1'b0;
                end
            end
            ARA_RT0: begin
                if (done) begin
                    rt0_d = conv_code;
                    if (rt_two) begin
                        st_d = ARA_RT1;
                        mux_d = rt_second;
                        start = 1'b1;
                    end else begin
                        st_d = ARA_IDLE;
                        rt_irq_d = ~realtime_irq_mask;
                        act_d = 1'b0;
                    end
                end
            end
            ARA_RT1: begin
                if (done) begin
                    rt1_d = conv_code;
                    st_d = ARA_IDLE;
                    rt_irq_d = ~realtime_irq_mask;
                    act_d = 1'b0;
                end
            end
            ARA_SOFT, ARA_CHG: begin
                if (rt_pend_d) begin
                    // Abort; soft pending flag stays set, charger flag is set again, so it reruns
                    abort = 1'b1;
                    if (st_q == ARA_CHG) begin
                        chg_pend_d = 1'b1;
                    end
                    st_d = ARA_IDLE;
                    act_d = 1'b0;
                end else if (done) begin
                    st_d = ARA_IDLE;
                    act_d = 1'b0;
                    if (st_q == ARA_SOFT) begin
                        swl_d = conv_code[7:0];
                        swh_d = {4'h0, conv_code[11:8]};
                        sw_irq_d = ~soft_irq_mask;
                        sw_pend_d = soft_conv_request_bit & adc_enable_toggle &
                            chan_ok(soft_channel_select, power_path_fuse);
                    end else begin
                        chg_d = conv_code;
                        chg_v_d = 1'b1;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            st_q <= ARA_IDLE;
            rt_pend_q <= 1'b0;
            sw_pend_q <= 1'b0;
            chg_pend_q <= 1'b0;
            trig_q <= 1'b0;
            mux_chan <= '0;
            conv_active <= 1'b0;
            soft_result_low <= 8'h00;
            soft_result_high <= 8'h00;
            realtime_result0 <= `ARA_CODE_MIN;
            realtime_result1 <= `ARA_CODE_MIN;
            charger_result <= `ARA_CODE_MIN;
            charger_result_valid <= 1'b0;
            soft_conv_done_irq <= 1'b0;
            realtime_conv_done_irq <= 1'b0;
            soft_pending <= 1'b0;
        end else begin
            st_q <= st_d;
            rt_pend_q <= rt_pend_d;
            sw_pend_q <= sw_pend_d;
            chg_pend_q <= chg_pend_d;
            trig_q <= hw_trigger_pin;
            mux_chan <= mux_d;
            conv_active <= act_d;
            soft_result_low <= swl_d;
            soft_result_high <= swh_d;
            realtime_result0 <= rt0_d;
            realtime_result1 <= rt1_d;
            charger_result <= chg_d;
            charger_result_valid <= chg_v_d;
            soft_conv_done_irq <= sw_irq_d;
            realtime_conv_done_irq <= rt_irq_d;
            soft_pending <= sw_pend_d;
        end
    end

    // Checks
    a_chg_forces_mux: assert property (@(posedge core_clk) disable iff (srst)
        st_q == ARA_CHG |-> mux_chan == `ARA_CHG_CHAN)
        else $error("charger conversion not on channel 17");
    a_chg_no_irq: assert property (@(posedge core_clk) disable iff (srst)
        charger_result_valid |-> !soft_conv_done_irq &&
        !realtime_conv_done_irq)
        else $error("interrupt raised for charger conversion");
    a_rt_over_soft: assert property (@(posedge core_clk) disable iff (srst)
        st_q == ARA_IDLE && rt_pend_d |=> st_q == ARA_RT0)
        else $error("realtime not granted first");
    a_rt_aborts: assert property (@(posedge core_clk) disable iff (srst)
        (st_q == ARA_SOFT || st_q == ARA_CHG) && rt_pend_d
        |=> st_q == ARA_IDLE ##1 st_q == ARA_RT0)
        else $error("realtime did not abort lower work");
    a_soft_irq_mask: assert property (@(posedge core_clk) disable iff (srst)
        soft_conv_done_irq |-> !$past(soft_irq_mask))
        else $error("soft irq while masked");
    a_rt_irq_mask: assert property (@(posedge core_clk) disable iff (srst)
        realtime_conv_done_irq |-> !$past(realtime_irq_mask))
        else $error("realtime irq while masked");
    a_soft_holds: assert property (@(posedge core_clk) disable iff (srst)
        (st_q == ARA_RT0 || st_q == ARA_CHG) && sw_pend_q && !done
        |=> sw_pend_q)
        else $error("held soft request lost");
    a_fuse_ch11: assert property (@(posedge core_clk) disable iff (srst)
        conv_active && power_path_fuse && st_q == ARA_SOFT
        |-> mux_chan != `ARA_BUSREG_CHAN)
        else $error("channel 11 used with power path");
    a_soft_high_zero: assert property (@(posedge core_clk) disable iff (srst)
        soft_result_high[7:4] == 4'h0)
        else $error("soft result exceeds 12 bits");
endmodule : ara_arbiter

// ==== tb/ara_conv_model.sv ====
// Behavioural converter that answers the arbiter's channel select
`timescale 1ns/1ps
module ara_conv_model (
    // Clock
    input wire logic core_clk,
    // Converter control
    input wire logic conv_active,
    input wire logic [4:0] mux_chan,
    // Converted code
    output logic [11:0] conv_code
);
    logic junk_q = 1'b0;
    // Toggles while idle so a stale code never passes for a result
    always @(posedge core_clk) junk_q <= ~junk_q;
    always_comb begin
        if (conv_active !== 1'b1)
            conv_code = {12{junk_q}};
        else if (mux_chan == 5'h00)
            conv_code = 12'h000;
        else if (mux_chan == 5'h12)
            conv_code = 12'hfff;
        else
            conv_code = {mux_chan, 7'h2a};
    end
endmodule : ara_conv_model

// ==== tb/adc_request_arbiter_tb.sv ====
// Self-checking bench for the conversion request arbiter
`timescale 1ns/1ps
module adc_request_arbiter_tb;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic adc_enable_toggle = 1'b0;
    logic [4:0] soft_channel_select = 5'h00;
    logic soft_conv_request_bit = 1'b0;
    logic [18:0] realtime_chan_sel = 19'h00000;
    logic soft_irq_mask = 1'b0;
    logic realtime_irq_mask = 1'b0;
    logic power_path_fuse = 1'b1;
    logic hw_trigger_pin = 1'b0;
    logic charger_monitor = 1'b0;
    logic [11:0] conv_code, realtime_result0, realtime_result1;
    logic [11:0] charger_result;
    logic [4:0] mux_chan, first_mux;
    logic [7:0] soft_result_low, soft_result_high;
    logic conv_active, charger_result_valid, soft_conv_done_irq;
    logic realtime_conv_done_irq, soft_pending, act_q;
    int miscompares = 0;
    int comparisons = 0;
    int n_s, n_r, n_c, n_st;
    always #2.5 core_clk = ~core_clk;
    ara_arbiter #(.CONV_CYC(4)) uut (.core_clk, .srst, .adc_enable_toggle,
        .soft_channel_select, .soft_conv_request_bit, .realtime_chan_sel,
        .soft_irq_mask, .realtime_irq_mask, .power_path_fuse,
        .hw_trigger_pin, .charger_monitor, .conv_code, .mux_chan,
        .conv_active, .soft_result_low, .soft_result_high,
        .realtime_result0, .realtime_result1, .charger_result,
        .charger_result_valid, .soft_conv_done_irq,
        .realtime_conv_done_irq, .soft_pending);
    ara_conv_model model (.core_clk, .conv_active, .mux_chan, .conv_code);
    // Event counters; first channel of each scenario kept for priority
    always @(posedge core_clk) begin
        act_q <= conv_active;
        if (soft_conv_done_irq === 1'b1) n_s++;
        if (realtime_conv_done_irq === 1'b1) n_r++;
        if (charger_result_valid === 1'b1) n_c++;
        if (conv_active === 1'b1 && act_q !== 1'b1) begin
            if (n_st == 0) first_mux = mux_chan;
            n_st++;
        end
    end
    function automatic logic [11:0] code(input logic [4:0] c);
        if (c == 5'h00) return 12'h000;
        if (c == 5'h12) return 12'hfff;
        return {c, 7'h2a};
    endfunction : code
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask : cyc
    task automatic clr;
        n_s = 0; n_r = 0; n_c = 0; n_st = 0; first_mux = 5'h1f;
    endtask : clr
    task automatic soft_req(input logic [4:0] c);
        soft_channel_select = c;
        soft_conv_request_bit = 1'b1;
        cyc(1);
        soft_conv_request_bit = 1'b0;
    endtask : soft_req
    task automatic trig(input logic [18:0] s);
        realtime_chan_sel = s;
        hw_trigger_pin = 1'b1;
        cyc(1);
        hw_trigger_pin = 1'b0;
    endtask : trig
    task automatic wait_r;
        for (int i = 0; i < 60 && n_r == 0; i++) cyc(1);
    endtask : wait_r
    task automatic wait_c;
        for (int i = 0; i < 60 && n_c == 0; i++) cyc(1);
    endtask : wait_c
    task automatic t_soft;
        logic [4:0] ch [3] = '{5'h00, 5'h05, 5'h12};
        adc_enable_toggle = 1'b1;
        foreach (ch[i]) begin
            clr; soft_req(ch[i]); cyc(20);
            chk(n_s, 1);
            chk(first_mux, ch[i]);
            chk({soft_result_high, soft_result_low}, code(ch[i]));
        end
        soft_irq_mask = 1'b1;
        clr; soft_req(5'h06); cyc(20);
        chk(n_s, 0);
        chk(soft_result_low, code(5'h06) & 12'h0ff);
        soft_irq_mask = 1'b0;
        $display("test soft done");
    endtask : t_soft
    task automatic t_chg;
        adc_enable_toggle = 1'b0;
        clr; charger_monitor = 1'b1; wait_c; charger_monitor = 1'b0; cyc(10);
        chk(n_c != 0, 1);
        chk(first_mux, 5'h11);
        chk(charger_result, code(5'h11));
        chk(n_s + n_r, 0);
        power_path_fuse = 1'b0;
        clr; charger_monitor = 1'b1; cyc(20); charger_monitor = 1'b0;
        chk(n_st, 0);
        power_path_fuse = 1'b1;
        $display("test charger done");
    endtask : t_chg
    task automatic t_fuse;
        adc_enable_toggle = 1'b1;
        clr; soft_req(5'h0b); cyc(15);
        power_path_fuse = 1'b0;
        soft_req(5'h11); cyc(15);
        chk(n_st, 0);
        soft_req(5'h0b); cyc(20);
        chk(n_s, 1);
        power_path_fuse = 1'b1;
        $display("test fuse done");
    endtask : t_fuse
    task automatic t_hold;
        clr; trig(19'h00214); cyc(2);
        soft_req(5'h07); cyc(1); soft_req(5'h07);
        chk(soft_pending, 1);
        wait_r;
        chk(n_s, 0);
        chk(realtime_result0, code(5'h02));
        chk(realtime_result1, code(5'h04));
        cyc(30);
        chk(n_s, 1);
        chk(soft_result_low, code(5'h07) & 12'h0ff);
        $display("test hold done");
    endtask : t_hold
    task automatic t_abort;
        clr; soft_req(5'h09); cyc(2); trig(19'h00008); wait_r;
        chk(n_s, 0);
        chk(realtime_result0, code(5'h03));
        cyc(20);
        chk(n_s, 1);
        chk(soft_result_low, code(5'h09) & 12'h0ff);
        clr; charger_monitor = 1'b1; cyc(1); charger_monitor = 1'b0;
        cyc(2); trig(19'h00020); wait_r; wait_c;
        chk(n_c, 1);
        chk(first_mux, 5'h11);
        chk(realtime_result0, code(5'h05));
        $display("test abort done");
    endtask : t_abort
    task automatic t_prio;
        clr; soft_channel_select = 5'h05;
        soft_conv_request_bit = 1'b1; charger_monitor = 1'b1;
        cyc(1); soft_conv_request_bit = 1'b0;
        wait_c; charger_monitor = 1'b0;
        chk(first_mux, 5'h11);
        cyc(20);
        chk(n_s, 1);
        realtime_irq_mask = 1'b1;
        clr; charger_monitor = 1'b1; trig(19'h00040);
        wait_c; charger_monitor = 1'b0;
        chk(first_mux, 5'h06);
        chk(n_r, 0);
        chk(realtime_result0, code(5'h06));
        realtime_irq_mask = 1'b0; cyc(10);
        $display("test priority done");
    endtask : t_prio
    task automatic final_report;
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : final_report
    // Whole run needs about 320 cycles; generous margin
    initial begin
        #50000;
        miscompares++;
        final_report;
    end
    initial begin
        clr;
        cyc(12);
        srst = 1'b0;
        cyc(2);
        t_soft; t_chg; t_fuse; t_hold; t_abort; t_prio;
        final_report;
    end
endmodule : adc_request_arbiter_tb
